// ---- src/acp_pkg.sv ----
// Shared constants and carrier types of the converter serial port.
// Assumes one core clock; all pins reach the port through synchronisers.
package acp_pkg;

   // Word sizes
   localparam int RES_W = 12;
   localparam int CNT_W = 4;
   localparam int CMD_W = 4;
   localparam int IN_W  = 8;

   // Frame edge counts
   localparam logic [CNT_W-1:0] ADDR_RISES  = 4'h4;
   localparam logic [CNT_W-1:0] IN_RISES    = 4'h8;
   localparam logic [CNT_W-1:0] SAMPLE_FALL = 4'h4;
   localparam logic [CNT_W-1:0] FRAME_CLKS  = 4'hc;

   // Configuration field positions
   localparam int CFG_LSB_BIT = 0;
   localparam int CFG_EOC_BIT = 1;

   // Reset values
   localparam logic [CMD_W-1:0] CFG_RST    = 4'h0;
   localparam logic             STATUS_RST = 1'h1;
   localparam logic [2:0]       PINS_RST   = 3'h4;

   // Frame phase of the serial port
   typedef enum logic [0:0] {PH_IDLE, PH_FRAME} acpPhase_t;

   // Host pins, in synchroniser bit order
   typedef struct packed {
      logic csN;
      logic ioClk;
      logic dataIn;
   } acpPins_t;

   // Conversion control toward the analog core
   typedef struct packed {
      logic             sample;
      logic             start;
      logic [CMD_W-1:0] chan;
   } acpConv_t;

endpackage

// ---- src/acp_sync3.sv ----
// Three-stage pin synchroniser with agreement filter for the host pins.
// Assumes asynchronous pins; output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module acp_sync3
   import acp_pkg::*;
(
   input  wire logic     core_clk,
   input  wire logic     srst,
   input  wire logic     ce,
   input  wire acpPins_t pinIn,
   output acpPins_t      pinOut
);

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] flt;
   } acpSyncState_t;

   acpSyncState_t q;
   acpSyncState_t d;
   logic [2:0]    fltD;

   // Per bit: take the level once the two later stages agree
   for (genvar i = 0; i < 3; i++)
   begin : g_bit
      assign fltD[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.flt[i];
   end

   // Next state
   always_comb
   begin
      d     = q;
      d.s1  = pinIn;
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.flt = fltD;
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         q <= {PINS_RST, PINS_RST, PINS_RST, PINS_RST};
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   assign pinOut = acpPins_t'(q.flt);

endmodule
`default_nettype wire

// ---- src/acp_buf2.sv ----
// Two-entry result buffer between the analog core and the serial port.
// Assumes a same-clock producer; inReady stalls it when both entries hold.
`timescale 1ns/1ps
`default_nettype none
module acp_buf2
   import acp_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic             inValid,
   input  wire logic [RES_W-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic [RES_W-1:0]      outData,
   input  wire logic             outReady
);

   typedef struct packed {
      logic [1:0][RES_W-1:0] mem;
      logic                  wp;
      logic                  rp;
      logic [1:0]            cnt;
   } acpBufState_t;

   acpBufState_t q;
   acpBufState_t d;
   logic         push;
   logic         pop;

   // Honest full and empty
   assign inReady  = (q.cnt != 2'h2);
   assign outValid = (q.cnt != 2'h0);
   assign outData  = q.mem[q.rp];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Next state
   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = inData;
         d.wp        = ~q.wp;
      end
      if (pop)
      begin
         d.rp = ~q.rp;
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         q <= '0;
      end
      else if (ce)
      begin
         q <= d;
      end
   end

endmodule
`default_nettype wire

// ---- src/acp_port.sv ----
// Serial host port and conversion sequencing of the converter.
// Assumes host pins arrive asynchronously; the analog core returns each
// result word through a valid/ready pair on the core clock.
`timescale 1ns/1ps
`default_nettype none
module acp_port
   import acp_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic             csN,
   input  wire logic             ioClk,
   input  wire logic             dataIn,
   output logic                  dataOut,
   output logic                  dataOutOe,
   output logic                  statusN,
   output acpConv_t              convCtl,
   input  wire logic             resValid,
   input  wire logic [RES_W-1:0] resData,
   output logic                  resReady
);

   typedef struct packed {
      logic             csP;
      logic             clkP;
      acpPhase_t        ph;
      logic [CNT_W-1:0] rise;
      logic [CNT_W-1:0] fall;
      logic [IN_W-1:0]  inSh;
      logic [CMD_W-1:0] commandRegister;
      logic [CMD_W-1:0] cfg;
      logic [RES_W-1:0] outSh;
      logic [RES_W-1:0] result;
      logic             dout;
      logic             lsbOrd;
      logic             oe;
      logic             sample;
      logic             start;
      logic             busy;
      logic             statN;
   } acpState_t;

   acpState_t        q;
   acpState_t        d;
   acpPins_t         pinRaw;
   acpPins_t         pin;
   logic             bufValid;
   logic [RES_W-1:0] bufData;
   logic             bufReady;
   logic             lsbFirst;
   logic             eocMode;
   logic             csFall;
   logic             csRise;
   logic             inFrame;
   logic             clkRise;
   logic             clkFall;
   logic             convDone;
   logic             firstBit;
   logic [IN_W-1:0]  nextSh;
   logic [CMD_W-1:0] nextNib;
   logic [RES_W-1:0] shiftOut;

   assign pinRaw = '{csN: csN, ioClk: ioClk, dataIn: dataIn};

   // Host pins into the core clock domain
   acp_sync3 u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .ce       (ce),
      .pinIn    (pinRaw),
      .pinOut   (pin)
   );

   // Result words wait here until the controller drains them
   acp_buf2 u_buf (
      .core_clk (core_clk),
      .srst     (srst),
      .ce       (ce),
      .inValid  (resValid),
      .inData   (resData),
      .inReady  (resReady),
      .outValid (bufValid),
      .outData  (bufData),
      .outReady (bufReady)
   );

   // Programmed options
   assign lsbFirst = q.cfg[CFG_LSB_BIT];
   assign eocMode  = q.cfg[CFG_EOC_BIT];

   // Edge detection on filtered pins; clock edges count only inside a frame
   assign csFall   = q.csP & ~pin.csN;
   assign csRise   = ~q.csP & pin.csN;
   assign inFrame  = (q.ph == PH_FRAME) & ~pin.csN;
   assign clkRise  = inFrame & ~q.clkP & pin.ioClk;
   assign clkFall  = inFrame & q.clkP & ~pin.ioClk;

   // Drain the buffer only while a conversion is outstanding
   assign bufReady = q.busy;
   assign convDone = q.busy & bufValid;

   // Serial data helpers
   assign firstBit = lsbFirst ? q.result[0] : q.result[RES_W-1];
   assign nextSh   = {q.inSh[IN_W-2:0], pin.dataIn};
   assign nextNib  = nextSh[CMD_W-1:0];
   assign shiftOut = q.lsbOrd ? {1'b0, q.outSh[RES_W-1:1]}  // Order frozen for the frame
                              : {q.outSh[RES_W-2:0], 1'b0};

   // Next state of the port
   always_comb
   begin
      d       = q;
      d.csP   = pin.csN;
      d.clkP  = pin.ioClk;
      d.start = 1'b0;
      unique case (q.ph)
         PH_IDLE:
         begin
            if (csFall)
            begin
               d.ph     = PH_FRAME;
               d.rise   = '0;
               d.fall   = '0;
               d.inSh   = '0;
               d.sample = 1'b0;
               d.outSh  = q.result;
               d.oe     = 1'b1;
               d.dout   = firstBit;
               d.lsbOrd = lsbFirst;
            end
         end
         PH_FRAME:
         begin
            if (csRise)
            begin
               d.ph     = PH_IDLE;
               d.oe     = 1'b0;
               d.sample = 1'b0;
            end
            else
            begin
               if (clkRise)
               begin
                  if (!eocMode)
                  begin
                     d.statN = 1'b1;
                  end
                  if (q.rise != IN_RISES)
                  begin
                     d.rise = q.rise + 4'h1;
                     d.inSh = nextSh;
                     if (d.rise == ADDR_RISES)
                     begin
                        d.commandRegister = nextNib;
                     end
                     if (d.rise == IN_RISES)
                     begin
                        d.cfg = nextNib;
                     end
                  end
               end
               if (clkFall && q.fall != FRAME_CLKS)
               begin
                  d.fall  = q.fall + 4'h1;
                  d.outSh = shiftOut;
                  d.dout  = q.lsbOrd ? shiftOut[0] : shiftOut[RES_W-1];
                  if (d.fall == SAMPLE_FALL)
                  begin
                     d.sample = 1'b1;
                  end
                  if (d.fall == FRAME_CLKS)
                  begin
                     d.sample = 1'b0;
                     d.start  = 1'b1;
                     d.busy   = 1'b1;
                     if (eocMode)
                     begin
                        d.statN = 1'b0;
                     end
                  end
               end
            end
         end
      endcase
      // Completion last, so it wins over a clear in the same cycle
      if (convDone)
      begin
         d.result = bufData;
         d.busy   = d.start;                                // A hand-over now stays busy
         d.statN  = eocMode & ~d.start;
      end
   end

   // State register; clock enable freezes everything
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         q       <= '0;
         q.csP   <= 1'b1;
         q.ph    <= PH_IDLE;
         q.cfg   <= CFG_RST;
         q.statN <= STATUS_RST;
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   // Outputs straight from flops
   assign dataOut        = q.dout;
   assign dataOutOe      = q.oe;
   assign statusN        = q.statN;
   assign convCtl.sample = q.sample;
   assign convCtl.start  = q.start;
   assign convCtl.chan   = q.commandRegister;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst || !ce);

   AST_CS_FALL_RESET: assert property (
      csFall |=> q.rise == 4'h0 && q.fall == 4'h0 && inFrame)
      else $error("Counters not cleared at select fall");

   AST_CS_HIGH_IGNORED: assert property (
      pin.csN && !csRise |=> $stable(q.rise) && $stable(q.inSh))
      else $error("Input taken while select high");

   AST_ADDR_AFTER_FOURTH: assert property (
      clkRise && q.rise == 4'h3 |=> convCtl.chan == $past(nextNib))
      else $error("Channel not loaded on fourth rise");

   AST_CFG_ON_EIGHTH: assert property (
      clkRise && q.rise == 4'h7 |=> q.cfg == $past(nextNib))
      else $error("Configuration not loaded on eighth rise");

   AST_OUT_FLOAT: assert property (
      pin.csN && $past(pin.csN) && !csRise |-> !dataOutOe)
      else $error("Output driven while select high");

   AST_FIRST_BIT: assert property (
      csFall |=> dataOutOe && dataOut == $past(firstBit))
      else $error("Wrong first result bit");

   AST_CHANGE_ON_FALL: assert property (
      !clkFall && !csFall |=> $stable(dataOut))
      else $error("Output moved without a falling edge");

   AST_SAMPLE_START: assert property (
      clkFall && q.fall == 4'h3 && !csRise |=> convCtl.sample ##1 convCtl.sample)
      else $error("Sampling not started on fourth fall");

   AST_HANDOVER: assert property (
      clkFall && q.fall == 4'hb && !csRise |=> convCtl.start && !convCtl.sample && q.busy)
      else $error("No handover on last fall");

   AST_EOC_LOW: assert property (
      clkFall && q.fall == 4'hb && eocMode && !csRise && !convDone |=> !statusN)
      else $error("End-of-conversion not low after last fall");

   AST_DONE_STATUS: assert property (
      convDone && !d.start |=> statusN == $past(eocMode) && !q.busy)
      else $error("Status wrong at completion");

   AST_INT_CLEAR: assert property (
      clkRise && !eocMode && !convDone |=> statusN)
      else $error("Interrupt not cleared by clock rise");

   AST_NEXT_BIT: assert property (
      clkFall && q.fall != FRAME_CLKS |=> dataOut == $past(q.lsbOrd ? q.outSh[1] : q.outSh[RES_W-2]))
      else $error("Wrong next result bit after falling edge");

   COV_FRAME:   cover property (csFall ##[1:300] csRise);
   COV_EOC:     cover property (convCtl.start && eocMode);
   COV_CONVERT: cover property (convCtl.start ##[1:1000] convDone);
   COV_LSB:     cover property (csFall && lsbFirst);

endmodule
`default_nettype wire

// ---- bench/acp_host_model.sv ----
// Host serial master model for the converter port: select, shift clock, command.
// Assumes the port's core clock; pins change only on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module acp_host_model
(
   input  wire logic core_clk,
   input  wire logic dataOut,
   input  wire logic dataOutOe,
   output logic      csN,
   output logic      ioClk,
   output logic      dataIn
);
   logic lastQ = 1'b0;
   logic lineLvl;

   // Released line shows the inverse of the last driven bit
   always @(posedge core_clk)
   begin
      if (dataOutOe === 1'b1)
      begin
         lastQ <= dataOut;
      end
   end
   assign lineLvl = dataOutOe ? dataOut : ~lastQ;

   // Idle pins: select high, shift clock low and quiet
   initial
   begin
      csN    = 1'b1;
      ioClk  = 1'b0;
      dataIn = 1'b0;
   end

   // One frame of nClk pulses at 400 ns; result bits taken before each fall
   task automatic frame(input logic [7:0] cmd, input int nClk, output logic [11:0] rx);
      rx  = 12'h000;
      csN = 1'b0;
      repeat (8) @(negedge core_clk);
      for (int i = 0; i < nClk; i++)
      begin
         dataIn = (i < 8) ? cmd[7-i] : 1'b0;
         repeat (4) @(negedge core_clk);
         ioClk = 1'b1;
         repeat (4) @(negedge core_clk);
         rx[11-i] = lineLvl;
         ioClk    = 1'b0;
      end
      repeat (8) @(negedge core_clk);
      csN    = 1'b1;
      dataIn = 1'b0;
      repeat (8) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// ---- bench/test_adc_serial_conversion_port.sv ----
// Self-checking bench for the converter serial port with a host model.
// Assumes a 20 MHz core clock; the bench plays the analog core's result feed.
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_conversion_port
   import acp_pkg::*;
   ;
   typedef struct packed {
      logic [7:0]  cmd;
      logic [11:0] feed;
      logic [11:0] expRx;
      logic        rev;
   } acpRow_t;

   logic             core_clk = 1'b0;
   logic             srst     = 1'b1;
   logic             csN;
   logic             ioClk;
   logic             dataIn;
   logic             dataOut;
   logic             dataOutOe;
   logic             statusN;
   acpConv_t         convCtl;
   logic             resValid = 1'b0;
   logic [RES_W-1:0] resData  = 12'h000;
   logic             resReady;
   logic [11:0]      rx;
   int               errors   = 0;
   int               checks   = 0;
   int               startCnt = 0;
   int               expStart = 0;
   int               sampleCnt = 0;
   acpRow_t          rows [4] = '{'{8'h30, 12'ha5c, 12'h000, 1'b0},
                                  '{8'h91, 12'h3c1, 12'ha5c, 1'b0},
                                  '{8'hc2, 12'h7e4, 12'h3c1, 1'b1},
                                  '{8'h50, 12'h1b6, 12'h7e4, 1'b0}};
   logic [11:0]      bufExp [3] = '{12'h1b6, 12'h2d3, 12'h4e8};

   // Core clock, 50 ns period
   always #25 core_clk = ~core_clk;

   // Count conversion hand-overs and sampling cycles
   always_ff @(posedge core_clk)
   begin
      if (convCtl.start === 1'b1)
      begin
         startCnt <= startCnt + 1;
      end
      if (convCtl.sample === 1'b1)
      begin
         sampleCnt <= sampleCnt + 1;
      end
   end

   acp_port u_dut (
      .core_clk  (core_clk),
      .srst      (srst),
      .ce        (1'b1),
      .csN       (csN),
      .ioClk     (ioClk),
      .dataIn    (dataIn),
      .dataOut   (dataOut),
      .dataOutOe (dataOutOe),
      .statusN   (statusN),
      .convCtl   (convCtl),
      .resValid  (resValid),
      .resData   (resData),
      .resReady  (resReady)
   );

   acp_host_model u_host (
      .core_clk  (core_clk),
      .dataOut   (dataOut),
      .dataOutOe (dataOutOe),
      .csN       (csN),
      .ioClk     (ioClk),
      .dataIn    (dataIn)
   );

   // Verdict and end of run
   task automatic final_report();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Single-bit comparison
   task automatic checkBit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Word comparison
   task automatic checkWord(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bit order of a word sent least significant first
   function automatic logic [11:0] rev12(input logic [11:0] v);
      for (int i = 0; i < 12; i++)
         rev12[i] = v[11-i];
   endfunction

   // Offer one result word, held until the buffer takes it
   task automatic feedWord(input logic [11:0] w);
      int n;
      resData  = w;
      resValid = 1'b1;
      for (n = 0; n < 200 && resReady !== 1'b1; n++)
         @(negedge core_clk);
      @(negedge core_clk);
      resValid = 1'b0;
      @(negedge core_clk);
      if (n == 200)
      begin
         errors++;
         final_report();
      end
   endtask

   // Main sequence
   initial
   begin
      repeat (3) @(negedge core_clk);
      srst = 1'b0;
      checkBit("oeReset", 1'b0, dataOutOe);
      checkBit("statusReset", 1'b1, statusN);
      checkBit("readyReset", 1'b1, resReady);
      checkWord("convReset", 12'h000, {6'h00, convCtl});
      repeat (4) @(negedge core_clk);
      // Ordinary frames: commands, bit orders and both status modes
      for (int r = 0; r < 4; r++)
      begin
         u_host.frame(rows[r].cmd, 12, rx);
         expStart++;
         checkWord("result", rows[r].rev ? rev12(rows[r].expRx) : rows[r].expRx, rx);
         checkWord("chan", {8'h00, rows[r].cmd[7:4]}, {8'h00, convCtl.chan});
         checkBit("oeIdle", 1'b0, dataOutOe);
         checkWord("starts", 12'(expStart), 12'(startCnt));
         // Falls four to twelve, eight core clocks apart
         checkWord("samples", 12'((FRAME_CLKS - SAMPLE_FALL) * 8 * expStart), 12'(sampleCnt));
         if (rows[r].cmd[1])
            checkBit("statusBusy", 1'b0, statusN);
         feedWord(rows[r].feed);
         repeat (8) @(negedge core_clk);
         checkBit("statusDone", rows[r].cmd[1], statusN);
      end
      // Aborted frame: one rise clears the interrupt, no hand-over
      u_host.frame(8'hf3, 1, rx);
      checkBit("intClear", 1'b1, statusN);
      checkWord("abortStarts", 12'(expStart), 12'(startCnt));
      checkWord("abortSamples", 12'((FRAME_CLKS - SAMPLE_FALL) * 8 * expStart), 12'(sampleCnt));
      checkWord("abortChan", 12'h005, {8'h00, convCtl.chan});
      // Buffer filled while idle, then drained one word per conversion
      feedWord(12'h2d3);
      feedWord(12'h4e8);
      checkBit("bufFull", 1'b0, resReady);
      for (int k = 0; k < 3; k++)
      begin
         u_host.frame(8'h60, 12, rx);
         checkWord("bufResult", bufExp[k], rx);
         if (k == 0)
            checkBit("bufRoom", 1'b1, resReady);
      end
      final_report();
   end
endmodule
`default_nettype wire
